// ==== design/ddc_defs.vh ====
// Purpose: register offsets, field positions and counts for the DDC unit
// Assumes: 8-bit special-function register bus
// Notes:   definitions only
`ifndef DDC_DEFS_VH
`define DDC_DEFS_VH
`define OFS_BUFFER_WINDOW 8'hD4
`define OFS_LEGACY_TX     8'hD5
`define OFS_POINTER       8'hD6
`define OFS_CONTROL       8'hD7
`define BIT_SIZE_SEL      6
`define BIT_MANUAL        5
`define BIT_ADDR_SEL      4
`define BIT_BYTE_IRQ      3
`define BIT_LEGACY_EN     2
`define BIT_SWITCH_IRQ    1
`define BIT_MODE          0
`define RST_LEGACY_TX     8'h00
`define RST_POINTER       8'h00
`define RST_CONTROL       8'h00
`define SYNC_CLOCKS       4'h9
`define DDC_BASE_ADDR     7'h50
`define XDATA_BASE        8'hFF
`endif

// ==== design/byte_fifo.v ====
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/1ns
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
)(
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// drain side
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;
	wire            push;
	wire            pop;

	// extra pointer bit tells full from empty
	assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign push      = in_valid && !full;
	assign pop       = out_ready && !empty;

	// storage and pointers
	always @(posedge clk)
	begin
		if (rst)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	// head word always presented from a register
	always @(posedge clk)
	begin
		if (rst)
			out_data <= {WIDTH{1'b0}};
		else if (pop && (rd_q + 1'b1 != wr_q || push))
			out_data <= (rd_q + 1'b1 == wr_q) ? in_data
				: mem[rd_q[AW-1:0] + 1'b1];
		else if (empty && push)
			out_data <= in_data;
	end
endmodule // byte_fifo

// ==== design/ddc_unit.v ====
// Purpose: display data channel unit: buffer, pointer, legacy stream, 2-wire
// Assumes: 8-bit register bus on clk; vsync/scl/sda asynchronous pins
// Notes:   the two-wire slave engine proper is outside; it reports events
// How it works
// RULE1 - pointer steps by one after every window access, software or stream
// RULE2 - size bit: 0 gives 128 bytes, 1 gives 256 bytes
// RULE3 - manual bit clear: outgoing byte fetched from buffer at pointer
// RULE4 - manual bit set: interrupt each byte so software supplies next
// RULE5 - address select: 0 answers A0/A1 only, 1 ignores low three bits
// RULE6 - legacy manual mode sets byte flag on ninth clock; software clears
// RULE7 - legacy enable clear ignores vsync, two-wire still served
// RULE8 - switch flag set on move to two-wire mode; software clears
// RULE9 - mode bit reads 0 legacy, 1 two-wire; sticky until disabled
// RULE10 - unit enabled when legacy enable or two-wire enable is set
// RULE11 - disabled, automatic: idle, no irq, range goes to external space
// RULE12 - disabled, manual: software may preload buffer at FF00h-FFFFh
// RULE13 - enabled, automatic: hardware owns buffer, software blocked
// RULE14 - enabled, manual: buffer open to software, one irq per byte
// RULE15 - enabled, manual: each byte placed in shared shift data register
// RULE16 - unit tells legacy host from two-wire host types
// RULE17 - legacy transmit byte register readable, writable, resets to 0
// RULE18 - nine start-up vsync clocks with data line released
// RULE19 - at 128 bytes, increment wraps within the half that pointer bit 7 selects
// RULE20 - pointer wraps to zero; access uses pre-increment value
// RULE21 - legacy stream shifts msb first, one bit per vsync, ninth closes
`timescale 1ns/1ns
`include "ddc_defs.vh"
module ddc_unit #(
	parameter FIFO_DEPTH = 16
)(
	// clock and reset
	input  wire       clk,
	input  wire       rst,
	// special-function register bus
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_wdata,
	output reg  [7:0] sfr_rdata,
	// external data-space access to the buffer range
	input  wire [15:0] xdata_addr,
	input  wire       xdata_wr,
	input  wire       xdata_rd,
	input  wire [7:0] xdata_wdata,
	output reg  [7:0] xdata_rdata,
	output wire       xdata_hit,
	output wire       xdata_external,
	// two-wire controller shared state
	input  wire       two_wire_enable,
	input  wire       tw_addr_valid,
	input  wire [6:0] tw_addr,
	input  wire       tw_byte_req,
	input  wire       tw_byte_done,
	input  wire [7:0] two_wire_shift_data_in,
	output reg  [7:0] two_wire_shift_data,
	output reg        tw_shift_load,
	output wire       tw_addr_match,
	// link pins
	input  wire       vsync,
	input  wire       scl_in,
	output reg        sda_out,
	output reg        sda_oe,
	// interrupt request and host type to the core
	output wire       irq,
	output wire [1:0] host_type
);
	reg [2:0] vs_sync_q;
	reg [1:0] scl_sync_q;
	reg [7:0] legacy_tx_byte_q;
	reg [7:0] buffer_pointer_q;
	reg       size_q;
	reg       manual_q;
	reg       addr_sel_q;
	reg       byte_irq_q;
	reg       legacy_en_q;
	reg       switch_irq_q;
	reg       mode_q;
	reg [3:0] bit_cnt_q;
	reg [3:0] sync_cnt_q;
	reg [7:0] shift_q;
	reg       prefetch_q;
	reg [7:0] mem [0:255];
	wire      enabled;
	wire      vs_rise;
	wire      scl_fall;
	wire      sw_win;
	wire      hw_fetch;
	wire      buf_open;
	wire      f_in_ready;
	wire      f_out_valid;
	wire      f_pop;
	wire      ptr_wr;
	wire      f_clear;
	wire [7:0] f_out_data;
	wire [7:0] ctl_read;

	// next pointer value, wrapping in the active half when small
	function [7:0] step;
		input [7:0] p;
		input       big;
		begin
			if (big)
				step = p + 8'h01; // RULE20
			else
				step = {p[7], p[6:0] + 7'h01}; // RULE19
		end
	endfunction

	// pins pass two flops (scl) or three flops (vsync) before any use
	always @(posedge clk)
	begin
		if (rst)
		begin
			vs_sync_q  <= 3'h0;
			scl_sync_q <= 2'h3;
		end
		else
		begin
			vs_sync_q  <= {vs_sync_q[1:0], vsync};
			scl_sync_q <= {scl_sync_q[0], scl_in};
		end
	end

	// edges taken only from the second stage onward
	reg vs_last_q;
	reg scl_last_q;
	always @(posedge clk)
	begin
		if (rst)
		begin
			vs_last_q  <= 1'b0;
			scl_last_q <= 1'b1;
		end
		else
		begin
			vs_last_q  <= vs_sync_q[2];
			scl_last_q <= scl_sync_q[1];
		end
	end
	assign vs_rise  = vs_sync_q[2] && !vs_last_q;
	assign scl_fall = !scl_sync_q[1] && scl_last_q;

	assign enabled  = legacy_en_q || two_wire_enable; // RULE10
	assign buf_open = manual_q; // RULE12 RULE14
	assign sw_win   = sfr_addr == `OFS_BUFFER_WINDOW;
	assign xdata_hit = (xdata_addr[15:8] == `XDATA_BASE)
		&& (enabled || manual_q);
	// disabled automatic unit lets the range fall through
	assign xdata_external = !enabled && !manual_q; // RULE11

	// address compare; group match ignores the low three bits
	assign tw_addr_match = tw_addr_valid && (addr_sel_q ? // RULE5
		(tw_addr[6:3] == `DDC_BASE_ADDR >> 3) :
		(tw_addr == `DDC_BASE_ADDR));

	// hardware fetch only in automatic enabled operation
	assign hw_fetch = enabled && !manual_q && f_in_ready
		&& !prefetch_q; // RULE13
	assign f_pop = (!mode_q && legacy_en_q && !manual_q && vs_rise
		&& bit_cnt_q == 4'h8) || (mode_q && tw_byte_req && !manual_q);
	// prefetched bytes go stale once the pointer is written or automatic ends
	assign ptr_wr  = sfr_wr && sfr_addr == `OFS_POINTER;
	assign f_clear = rst || !enabled || manual_q || ptr_wr;

	// prefetch stage keeps the stream fed; stalls when full
	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.clk       (clk),
		.rst       (f_clear),
		.in_valid  (prefetch_q),
		.in_ready  (f_in_ready),
		.in_data   (mem[buffer_pointer_q]),
		.out_valid (f_out_valid),
		.out_ready (f_pop),
		.out_data  (f_out_data)
	);

	// register file, pointer, buffer writes
	always @(posedge clk)
	begin
		if (rst)
		begin
			legacy_tx_byte_q <= `RST_LEGACY_TX; // RULE17
			buffer_pointer_q <= `RST_POINTER;
			size_q           <= 1'b0; // RULE2
			manual_q         <= 1'b0;
			addr_sel_q       <= 1'b0;
			legacy_en_q      <= 1'b0; // RULE7
			prefetch_q       <= 1'b0;
		end
		else
		begin
			prefetch_q <= hw_fetch;
			if (ptr_wr)
				buffer_pointer_q <= sfr_wdata;
			else if (prefetch_q && f_in_ready && !f_clear)
				buffer_pointer_q <= step(buffer_pointer_q, size_q); // RULE1 RULE3
			else if (sfr_wr && sw_win && buf_open)
			begin
				mem[buffer_pointer_q] <= sfr_wdata; // RULE20
				buffer_pointer_q <= step(buffer_pointer_q, size_q); // RULE1
			end
			else if (sfr_rd && sw_win && buf_open)
				buffer_pointer_q <= step(buffer_pointer_q, size_q); // RULE1
			if (xdata_wr && xdata_hit && buf_open)
				mem[xdata_addr[7:0]] <= xdata_wdata; // RULE12
			if (sfr_wr && sfr_addr == `OFS_LEGACY_TX)
				legacy_tx_byte_q <= sfr_wdata; // RULE17
			if (sfr_wr && sfr_addr == `OFS_CONTROL)
			begin
				size_q      <= sfr_wdata[`BIT_SIZE_SEL];
				manual_q    <= sfr_wdata[`BIT_MANUAL];
				addr_sel_q  <= sfr_wdata[`BIT_ADDR_SEL];
				legacy_en_q <= sfr_wdata[`BIT_LEGACY_EN];
			end
		end
	end

	// flags: a hardware set beats a software clear in the same cycle
	wire ctl_wr = sfr_wr && sfr_addr == `OFS_CONTROL;
	wire set_byte = enabled && manual_q && !mode_q && legacy_en_q
		&& vs_rise && bit_cnt_q == 4'h8 && sync_cnt_q == 4'h0; // RULE6
	wire set_tw = enabled && mode_q && manual_q && tw_byte_done; // RULE14
	wire to_ddc2 = enabled && !mode_q && tw_addr_match;
	always @(posedge clk)
	begin
		if (rst)
		begin
			byte_irq_q   <= 1'b0;
			switch_irq_q <= 1'b0;
			mode_q       <= 1'b0;
		end
		else
		begin
			if (set_byte || set_tw) // RULE4
				byte_irq_q <= 1'b1;
			else if (ctl_wr && !sfr_wdata[`BIT_BYTE_IRQ])
				byte_irq_q <= 1'b0; // RULE6
			if (to_ddc2)
				switch_irq_q <= 1'b1; // RULE8
			else if (ctl_wr && !sfr_wdata[`BIT_SWITCH_IRQ])
				switch_irq_q <= 1'b0;
			if (!enabled)
				mode_q <= 1'b0; // RULE9
			else if (to_ddc2)
				mode_q <= 1'b1; // RULE9 RULE16
		end
	end

	// legacy stream: nine sync clocks, then 8 data bits and a ninth
	always @(posedge clk)
	begin
		if (rst)
		begin
			sync_cnt_q <= `SYNC_CLOCKS;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 8'h00;
			sda_out    <= 1'b1;
			sda_oe     <= 1'b0;
		end
		else if (!legacy_en_q || mode_q || !enabled)
		begin
			sync_cnt_q <= `SYNC_CLOCKS; // RULE7
			bit_cnt_q  <= 4'h0;
			sda_oe     <= 1'b0;
		end
		else if (vs_rise)
		begin
			if (sync_cnt_q != 4'h0)
			begin
				sync_cnt_q <= sync_cnt_q - 4'h1;
				sda_oe     <= 1'b0; // RULE18
			end
			else if (bit_cnt_q == 4'h8)
			begin
				bit_cnt_q <= 4'h0; // RULE21
				sda_oe    <= 1'b0;
			end
			else
			begin
				if (bit_cnt_q == 4'h0)
				begin
					// manual mode sends what software put in the byte
					shift_q <= manual_q ? {legacy_tx_byte_q[6:0], 1'b0}
						: {f_out_data[6:0], 1'b0};
					sda_out <= manual_q ? legacy_tx_byte_q[7]
						: f_out_data[7]; // RULE3 RULE21
				end
				else
				begin
					shift_q <= {shift_q[6:0], 1'b0};
					sda_out <= shift_q[7]; // RULE21
				end
				bit_cnt_q <= bit_cnt_q + 4'h1;
				sda_oe    <= 1'b1;
			end
		end
	end

	// shared shift data register for two-wire bytes
	always @(posedge clk)
	begin
		if (rst)
		begin
			two_wire_shift_data <= 8'h00;
			tw_shift_load       <= 1'b0;
		end
		else
		begin
			tw_shift_load <= mode_q && tw_byte_req;
			if (mode_q && tw_byte_req && !manual_q)
				two_wire_shift_data <= f_out_data; // RULE3
			else if (mode_q && manual_q && tw_byte_done)
				two_wire_shift_data <= two_wire_shift_data_in; // RULE15
		end
	end

	assign ctl_read = {1'b0, size_q, manual_q, addr_sel_q, byte_irq_q,
		legacy_en_q, switch_irq_q, mode_q};
	// interrupts silent while disabled
	assign irq = enabled && (byte_irq_q || switch_irq_q); // RULE11
	assign host_type = !enabled ? 2'h0 : (mode_q ? 2'h2 : 2'h1); // RULE16

	// read data registered; closed window reads zero
	always @(posedge clk)
	begin
		if (rst)
		begin
			sfr_rdata   <= 8'h00;
			xdata_rdata <= 8'h00;
		end
		else
		begin
			if (sfr_addr == `OFS_BUFFER_WINDOW)
				sfr_rdata <= buf_open ? mem[buffer_pointer_q] : 8'h00;
			else if (sfr_addr == `OFS_LEGACY_TX)
				sfr_rdata <= legacy_tx_byte_q;
			else if (sfr_addr == `OFS_POINTER)
				sfr_rdata <= buffer_pointer_q;
			else if (sfr_addr == `OFS_CONTROL)
				sfr_rdata <= ctl_read;
			else
				sfr_rdata <= 8'h00;
			xdata_rdata <= (xdata_rd && xdata_hit && buf_open)
				? mem[xdata_addr[7:0]] : 8'h00; // RULE13
		end
	end
	wire unused_scl = scl_fall;
endmodule // ddc_unit

// ==== tb/ddc_unit_chk.sv ====
// Purpose: port-level checks for the ddc unit
// Assumes: one clk domain, synchronous active-high rst
// Notes:   bound into every ddc_unit instance
`timescale 1ns/1ns
module ddc_unit_chk (
	// clock and reset
	input logic        clk,
	input logic        rst,
	// register bus and data space
	input logic        sfr_wr,
	input logic        sfr_rd,
	input logic [7:0]  sfr_addr,
	input logic [7:0]  sfr_wdata,
	input logic [7:0]  sfr_rdata,
	input logic [15:0] xdata_addr,
	input logic        xdata_hit,
	input logic        xdata_external,
	// two-wire side and link
	input logic        two_wire_enable,
	input logic        tw_addr_valid,
	input logic [6:0]  tw_addr,
	input logic        tw_addr_match,
	input logic [1:0]  host_type,
	input logic        vsync,
	input logic        sda_oe,
	input logic        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// write, idle, then read back of the transmit byte
	sequence tx_write_read;
		sfr_wr && sfr_addr == 8'hD5 ##1 !sfr_wr
			##1 sfr_rd && sfr_addr == 8'hD5;
	endsequence
	// nothing that could move the driver for longer than the sampler
	sequence link_quiet;
		(!sfr_wr && !tw_addr_valid && $stable(vsync)
			&& $stable(two_wire_enable))[*6];
	endsequence
	a_reset_quiet: assert property ($fell(rst) |-> !sda_oe && !irq)
		else $error("driver or irq active after reset");
	a_tx_readback: assert property (
		tx_write_read |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("transmit byte not read back");
	a_base_match: assert property (
		tw_addr_valid && two_wire_enable && tw_addr == 7'h50
		|-> tw_addr_match)
		else $error("base address not answered");
	a_group_only: assert property (
		tw_addr[6:3] != 4'hA |-> !tw_addr_match)
		else $error("foreign address answered");
	a_mode_switch: assert property (
		tw_addr_valid && tw_addr_match && two_wire_enable
		|-> ##[1:3] host_type == 2'h2)
		else $error("no move to two-wire mode");
	a_mode_sticky: assert property (
		host_type == 2'h2 ##1 (two_wire_enable && $past(two_wire_enable))
		|-> host_type == 2'h2)
		else $error("two-wire mode left while enabled");
	a_link_still: assert property (link_quiet |=> $stable(sda_oe))
		else $error("data driver moved without a link clock");
	a_xdata_range: assert property (
		xdata_hit |-> xdata_addr[15:8] == 8'hFF)
		else $error("buffer hit outside its range");
	a_hit_internal: assert property (xdata_hit |-> !xdata_external)
		else $error("buffer hit also sent outside");
endmodule // ddc_unit_chk

bind ddc_unit ddc_unit_chk u_chk (.clk(clk), .rst(rst), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .xdata_addr(xdata_addr), .xdata_hit(xdata_hit),
	.xdata_external(xdata_external), .two_wire_enable(two_wire_enable),
	.tw_addr_valid(tw_addr_valid), .tw_addr(tw_addr),
	.tw_addr_match(tw_addr_match), .host_type(host_type), .vsync(vsync),
	.sda_oe(sda_oe), .irq(irq));

// ==== tb/vsync_host.sv ====
// Purpose: legacy host model that clocks the link and samples data
// Assumes: data line has a pull-up when the unit releases it
// Notes:   vsync stands low outside frames; 400 ns per clock
`timescale 1ns/1ns
module vsync_host (
	// link pins
	output logic vsync,
	input  logic sda_out,
	input  logic sda_oe
);
	// pull-up decides a released line
	wire sda = sda_oe ? sda_out : 1'b1;
	initial vsync = 1'b0;
	// one clock; sample late so the 3-flop sampler has settled
	task pulse(output logic oe, output logic b);
		vsync = 1'b1;
		#200;
		vsync = 1'b0;
		#190;
		oe = sda_oe;
		b = sda;
		#10;
	endtask
endmodule // vsync_host

// ==== tb/display_data_channel_slave_test.sv ====
// Purpose: directed register-level test of the ddc unit
// Assumes: host model clocks the link; bench plays the two-wire engine
// Notes:   one line per test; counts printed before the verdict
`timescale 1ns/1ns
module display_data_channel_slave_test;
	// clock, reset and counters
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	int          bad_count = 0;
	int          comparisons = 0;
	// design inputs
	logic [7:0]  sfr_addr = 8'h00;
	logic [7:0]  sfr_wdata = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [15:0] xdata_addr = 16'h0000;
	logic        xdata_rd = 1'b0;
	logic        two_wire_enable = 1'b0;
	logic        tw_addr_valid = 1'b0;
	logic [6:0]  tw_addr = 7'h00;
	logic        tw_byte_req = 1'b0;
	logic        tw_byte_done = 1'b0;
	logic [7:0]  shift_in = 8'h00;
	logic        xdata_wr = 1'b0;
	logic [7:0]  xdata_wdata = 8'h00;
	// design outputs
	logic [7:0]  sfr_rdata, xdata_rdata, shift_data;
	logic        xdata_hit, xdata_external, tw_shift_load, tw_addr_match;
	logic        sda_out, sda_oe, irq, vsync;
	logic [1:0]  host_type;
	always #25 clk = ~clk;
	ddc_unit #(.FIFO_DEPTH(16)) DUT (.clk(clk), .rst(rst),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.xdata_addr(xdata_addr), .xdata_wr(xdata_wr), .xdata_rd(xdata_rd),
		.xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata),
		.xdata_hit(xdata_hit), .xdata_external(xdata_external),
		.two_wire_enable(two_wire_enable), .tw_addr_valid(tw_addr_valid),
		.tw_addr(tw_addr), .tw_byte_req(tw_byte_req),
		.tw_byte_done(tw_byte_done), .two_wire_shift_data_in(shift_in),
		.two_wire_shift_data(shift_data),
		.tw_shift_load(tw_shift_load), .tw_addr_match(tw_addr_match),
		.vsync(vsync), .scl_in(1'b1), .sda_out(sda_out), .sda_oe(sda_oe),
		.irq(irq), .host_type(host_type));
	vsync_host host (.vsync(vsync), .sda_out(sda_out), .sda_oe(sda_oe));
	task cyc;
		@(posedge clk);
		#5;
	endtask
	// x or z in the seen value never matches
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string w);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		cyc;
		sfr_wr = 1'b0;
		cyc;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a;
		sfr_rd = 1'b1;
		cyc;
		sfr_rd = 1'b0;
		chk(sfr_rdata, e, $sformatf("register %h", a));
		cyc;
	endtask
	task xrd(input logic [15:0] a, input logic h, input logic [7:0] e);
		xdata_addr = a;
		xdata_rd = 1'b1;
		#1 chk({xdata_hit, xdata_external}, {h, !h}, "data space map");
		cyc;
		xdata_rd = 1'b0;
		if (h)
			chk(xdata_rdata, e, "data space read");
		cyc;
	endtask
	task xwr(input logic [15:0] a, input logic [7:0] d);
		xdata_addr = a;
		xdata_wdata = d;
		xdata_wr = 1'b1;
		cyc;
		xdata_wr = 1'b0;
		cyc;
	endtask
	task probe(input logic [6:0] a, input logic e);
		tw_addr = a;
		tw_addr_valid = 1'b1;
		#1 chk(tw_addr_match, e, "address match");
		cyc;
		tw_addr_valid = 1'b0;
		cyc;
	endtask
	// nine sync clocks, eight data clocks, one closing clock
	task frame(input logic [7:0] e);
		logic o, b;
		int   i;
		#17;
		for (i = 0; i < 18; i++)
		begin
			host.pulse(o, b);
			if (i < 9 || i == 17)
				chk(o, 0, "link drive off");
			else
				chk({o, b}, {1'b1, e[16-i]}, "link bit");
		end
		cyc;
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		logic o, b;
		int   n;
		repeat (4) @(posedge clk);
		#5 rst = 1'b0;
		rd(8'hD5, 8'h00);
		rd(8'hD6, 8'h00);
		rd(8'hD7, 8'h00);
		$display("test reset values done");
		wr(8'hD7, 8'h20);
		wr(8'hD6, 8'h7E);
		wr(8'hD4, 8'hA1);
		wr(8'hD4, 8'hB2);
		wr(8'hD4, 8'hC3);
		rd(8'hD6, 8'h01);
		wr(8'hD6, 8'h7E);
		rd(8'hD4, 8'hA1);
		rd(8'hD4, 8'hB2);
		rd(8'hD4, 8'hC3);
		wr(8'hD7, 8'h60);
		wr(8'hD6, 8'hFF);
		wr(8'hD4, 8'h5A);
		rd(8'hD6, 8'h00);
		xrd(16'hFFFF, 1'b1, 8'h5A);
		xwr(16'hFF10, 8'h6D);
		xrd(16'hFF10, 1'b1, 8'h6D);
		wr(8'hD7, 8'h00);
		xrd(16'hFFFF, 1'b0, 8'h00);
		rd(8'hD4, 8'h00);
		rd(8'hD6, 8'h00);
		$display("test buffer window done");
		wr(8'hD7, 8'h60);
		wr(8'hD4, 8'hC5);
		wr(8'hD7, 8'h40);
		wr(8'hD6, 8'h00);
		wr(8'hD7, 8'h44);
		rd(8'hD4, 8'h00);
		chk({xdata_hit, xdata_external}, 2'b10, "data space map");
		frame(8'hC5);
		rd(8'hD7, 8'h44);
		$display("test automatic legacy stream done");
		wr(8'hD7, 8'h20);
		wr(8'hD5, 8'h3C);
		rd(8'hD5, 8'h3C);
		wr(8'hD7, 8'h24);
		frame(8'h3C);
		rd(8'hD7, 8'h2C);
		chk(irq, 1'b1, "irq");
		wr(8'hD7, 8'h24);
		chk(irq, 1'b0, "irq");
		$display("test manual legacy stream done");
		wr(8'hD6, 8'h00);
		wr(8'hD7, 8'h04);
		two_wire_enable = 1'b1;
		probe(7'h51, 1'b0);
		probe(7'h50, 1'b1);
		rd(8'hD7, 8'h07);
		chk(irq, 1'b1, "irq");
		wr(8'hD7, 8'h14);
		rd(8'hD7, 8'h15);
		probe(7'h57, 1'b1);
		probe(7'h58, 1'b0);
		tw_byte_req = 1'b1;
		cyc;
		tw_byte_req = 1'b0;
		for (n = 0; n < 8 && tw_shift_load !== 1'b1; n++)
			cyc;
		chk(tw_shift_load, 1'b1, "shift load");
		chk(shift_data, 8'hC5, "shift data");
		wr(8'hD7, 8'h34);
		shift_in = 8'h9D;
		tw_byte_done = 1'b1;
		cyc;
		tw_byte_done = 1'b0;
		chk(shift_data, 8'h9D, "shift data");
		rd(8'hD7, 8'h3D);
		chk(irq, 1'b1, "irq");
		two_wire_enable = 1'b0;
		wr(8'hD7, 8'h00);
		rd(8'hD7, 8'h00);
		two_wire_enable = 1'b1;
		probe(7'h50, 1'b1);
		repeat (3)
		begin
			host.pulse(o, b);
			chk(o, 1'b0, "link drive off");
		end
		$display("test two-wire mode done");
		tally_and_finish;
	end
endmodule // display_data_channel_slave_test
